// File: hdl/sec_regs_pkg.sv
// constants for the per-port counter, security and address register set
// ==========================================================
// Overview of operation
// - second 8-bit per-port counter counts enabled events, shows its live value
// - mask bits select clear-on-read and stop-at-maximum for that counter
// - byte read of 16-bit counter copies all bits; other byte then read from copy
// - config bit 0 enables learn mode for the port address memories only
// - config bit 1 enables address security checking for the port
// - bit 2 set passes all-ones destination frames, clear replaces them while bit 1 is set
// - source mismatch still counts as violation for passed broadcast or multicast
// - multicast is first destination byte lsb one; bit 3 passes, else replaced while bit 1 is set
// - read-only bit 4 shows source check result, one means mismatch
// - bit 5 set compares source address against stored addresses
// - bit 6 set compares destination address; both may be set
// - reserved config bit 7 always reads zero
// - each byte loaded into a location advances that location's byte pointer
// - pointer register holds pointer and valid flag for both locations
// - valid flag one marks the location valid, zero invalid
// - in learn mode pointer register shows learning progress and valid state
// - 48-bit address moves through one byte register in six accesses
// - accesses carry address bytes in ascending order, bits 7..0 first
package sec_regs_pkg;

  // ==========================================================
  // register indices, byte address is index times four
  localparam logic [5:0] IDX_CNT_TWO = 6'h11;
  localparam logic [5:0] IDX_CNT_LO  = 6'h12;
  localparam logic [5:0] IDX_CNT_HI  = 6'h13;
  localparam logic [5:0] IDX_MASK    = 6'h14;
  localparam logic [5:0] IDX_CFG     = 6'h15;
  localparam logic [5:0] IDX_PTR     = 6'h16;
  localparam logic [5:0] IDX_LOC1    = 6'h17;
  localparam logic [5:0] IDX_LOC2    = 6'h18;

  // ==========================================================
  // field positions
  localparam int CFG_LEARN  = 0;
  localparam int CFG_SEC    = 1;
  localparam int CFG_BCAST  = 2;
  localparam int CFG_MCAST  = 3;
  localparam int CFG_SAM    = 4;
  localparam int CFG_SRC    = 5;
  localparam int CFG_DST    = 6;
  localparam int MASK_CLR2  = 0;
  localparam int MASK_SAT2  = 1;
  localparam int MASK_CLR16 = 2;
  localparam int MASK_SAT16 = 3;
  localparam int PTR1_LSB   = 0;
  localparam int VALID1     = 3;
  localparam int PTR2_LSB   = 4;
  localparam int VALID2     = 7;

  // ==========================================================
  // reset values and fixed values
  localparam logic [7:0]  CFG_RST     = 8'h00;
  localparam logic [7:0]  CFG_WR_MASK = 8'h6F;
  localparam logic [7:0]  MASK_RST    = 8'h00;
  localparam logic [2:0]  PTR_RST     = 3'h0;
  localparam logic [2:0]  LAST_BYTE   = 3'h5;
  localparam logic [47:0] BCAST_ADDR  = 48'hFFFF_FFFF_FFFF;
  localparam int          CNT_TWO_W   = 8;
  localparam int          CNT_W       = 16;

  // next byte pointer, wraps after the sixth byte
  function automatic logic [2:0] ptr_next(input logic [2:0] p);
    ptr_next = (p == LAST_BYTE) ? PTR_RST : p + 3'h1;
  endfunction

  // stored address hit, only a valid location counts
  function automatic logic addr_hit(input logic [47:0] a,
                                    input logic [47:0] w,
                                    input logic        v);
    addr_hit = v & (a == w);
  endfunction

endpackage

// File: hdl/event_counter.sv
// event counter with clear-on-read and stop-at-maximum options
`timescale 1ns/1ps
module event_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             event_i,
  input  wire logic             clr_i,
  input  wire logic             sat_i,
  output logic [WIDTH-1:0]      count_o
);

  localparam logic [WIDTH-1:0] MAX = '1;

  logic [WIDTH-1:0] count_ff;
  logic             at_max;

  assign at_max  = (count_ff == MAX);
  assign count_o = count_ff;

  // ==========================================================
  // count; an event in the clearing cycle is kept as one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= '0;
    end else if (clr_i) begin
      count_ff <= event_i ? {{(WIDTH-1){1'b0}}, 1'b1} : '0;
    end else if (event_i && !(sat_i && at_max)) begin
      count_ff <= count_ff + 1'b1;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_cnt_step;
    event_i && !clr_i && !at_max |=> count_ff == $past(count_ff) + 1'b1;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("count did not step");

  property p_cnt_sat;
    event_i && !clr_i && sat_i && at_max |=> count_ff == MAX;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("count wrapped");

  c_cnt_wrap: cover property (event_i && !clr_i && !sat_i && at_max);

endmodule

// File: hdl/port_addr_mem.sv
// two port address locations of six bytes, byte and whole-word access
`timescale 1ns/1ps
module port_addr_mem (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        byte_we_i,
  input  wire logic        byte_re_i,
  input  wire logic        loc_i,
  input  wire logic [2:0]  idx_i,
  input  wire logic [7:0]  byte_i,
  input  wire logic        word_we_i,
  input  wire logic        word_loc_i,
  input  wire logic [47:0] word_i,
  output logic [7:0]       rd_data_o,
  output logic [47:0]      word0_o,
  output logic [47:0]      word1_o
);

  logic [7:0] mem_ff [2][6];
  logic [7:0] rd_ff;

  assign rd_data_o = rd_ff;

  // byte k of a location holds address bits 8k+7..8k
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      word0_o[8*k +: 8] = mem_ff[0][k];
      word1_o[8*k +: 8] = mem_ff[1][k];
    end
  end

  // ==========================================================
  // writes, a learned word wins over a byte write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < 6; k++) begin
        mem_ff[0][k] <= 8'h00;
        mem_ff[1][k] <= 8'h00;
      end
    end else if (word_we_i) begin
      for (int k = 0; k < 6; k++) begin
        mem_ff[word_loc_i][k] <= word_i[8*k +: 8];
      end
    end else if (byte_we_i && idx_i <= 3'h5) begin
      mem_ff[loc_i][idx_i] <= byte_i;
    end
  end

  // registered byte read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_ff <= 8'h00;
    end else if (byte_re_i) begin
      rd_ff <= (idx_i <= 3'h5) ? mem_ff[loc_i][idx_i] : 8'h00;
    end
  end

endmodule

// File: hdl/port_security_regs.sv
// per-port counters, security config and address memory behind wishbone
`timescale 1ns/1ps
module port_security_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        event_i,
  input  wire logic        event_two_i,
  input  wire logic        frame_check_i,
  input  wire logic [47:0] src_addr_i,
  input  wire logic [47:0] dst_addr_i,
  output logic             replace_o,
  output logic             violation_o
);

  // ==========================================================
  // bus decode
  logic       ack_ff;
  logic       take;
  logic       wr;
  logic       rd;
  logic [5:0] idx;

  assign take = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign idx  = wb_adr_i[7:2];
  assign wr   = take & wb_we_i & wb_sel_i[0];
  assign rd   = take & ~wb_we_i;

  // ==========================================================
  // state
  logic [7:0]  cfg_ff;
  logic [7:0]  mask_ff;
  logic        sam_ff;
  logic [2:0]  ptr1_ff;
  logic [2:0]  ptr2_ff;
  logic        valid1_ff;
  logic        valid2_ff;
  logic [15:0] hold_ff;
  logic        hold_vld_ff;
  logic        hold_hi_ff;
  logic [7:0]  dat_ff;
  logic        mem_sel_ff;
  logic        replace_ff;
  logic        violation_ff;

  logic [7:0]  cnt_two;
  logic [15:0] cnt16;
  logic [7:0]  mem_rd;
  logic [47:0] word0;
  logic [47:0] word1;

  // ==========================================================
  // frame check terms
  logic src_hit;
  logic dst_hit;
  logic src_mm;
  logic dst_mm;
  logic bcast;
  logic mcast;
  logic blocked;
  logic viol;
  logic learn;
  logic learn_loc;

  assign src_hit = sec_regs_pkg::addr_hit(src_addr_i, word0, valid1_ff)
                 | sec_regs_pkg::addr_hit(src_addr_i, word1, valid2_ff);
  assign dst_hit = sec_regs_pkg::addr_hit(dst_addr_i, word0, valid1_ff)
                 | sec_regs_pkg::addr_hit(dst_addr_i, word1, valid2_ff);
  assign src_mm  = cfg_ff[sec_regs_pkg::CFG_SRC] & ~src_hit;
  assign dst_mm  = cfg_ff[sec_regs_pkg::CFG_DST] & ~dst_hit;
  assign bcast   = (dst_addr_i == sec_regs_pkg::BCAST_ADDR);
  assign mcast   = dst_addr_i[0] & ~bcast;
  assign blocked = (bcast & ~cfg_ff[sec_regs_pkg::CFG_BCAST])
                 | (mcast & ~cfg_ff[sec_regs_pkg::CFG_MCAST]);
  assign viol    = cfg_ff[sec_regs_pkg::CFG_SEC] & (src_mm | dst_mm);

  // learn a new source into the first free location
  assign learn     = frame_check_i & cfg_ff[sec_regs_pkg::CFG_LEARN]
                   & ~src_hit & ~(valid1_ff & valid2_ff);
  assign learn_loc = valid1_ff;

  // ==========================================================
  // location access terms
  logic loc_acc;
  logic loc_sel;
  logic loc_valid;
  logic loc_wr;
  logic [2:0] loc_ptr;

  assign loc_acc   = take & (idx == sec_regs_pkg::IDX_LOC1 || idx == sec_regs_pkg::IDX_LOC2);
  assign loc_sel   = (idx == sec_regs_pkg::IDX_LOC2);
  assign loc_valid = loc_sel ? valid2_ff : valid1_ff;
  assign loc_ptr   = loc_sel ? ptr2_ff : ptr1_ff;
  assign loc_wr    = loc_acc & wr & ~loc_valid;

  // ==========================================================
  // sub-blocks
  event_counter #(
    .WIDTH (sec_regs_pkg::CNT_TWO_W)
  ) u_cnt_two (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .event_i (event_two_i),
    .clr_i   (rd & idx == sec_regs_pkg::IDX_CNT_TWO & mask_ff[sec_regs_pkg::MASK_CLR2]),
    .sat_i   (mask_ff[sec_regs_pkg::MASK_SAT2]),
    .count_o (cnt_two)
  );

  // clear-on-read of the wide counter happens when its copy is taken
  logic cnt_rd;
  logic capture;

  assign cnt_rd  = rd & (idx == sec_regs_pkg::IDX_CNT_LO || idx == sec_regs_pkg::IDX_CNT_HI);
  assign capture = cnt_rd & ~(hold_vld_ff & (hold_hi_ff != (idx == sec_regs_pkg::IDX_CNT_HI)));

  event_counter #(
    .WIDTH (sec_regs_pkg::CNT_W)
  ) u_cnt16 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .event_i (event_i),
    .clr_i   (capture & mask_ff[sec_regs_pkg::MASK_CLR16]),
    .sat_i   (mask_ff[sec_regs_pkg::MASK_SAT16]),
    .count_o (cnt16)
  );

  port_addr_mem u_mem (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .byte_we_i  (loc_wr),
    .byte_re_i  (loc_acc & rd),
    .loc_i      (loc_sel),
    .idx_i      (loc_ptr),
    .byte_i     (wb_dat_i[7:0]),
    .word_we_i  (learn),
    .word_loc_i (learn_loc),
    .word_i     (src_addr_i),
    .rd_data_o  (mem_rd),
    .word0_o    (word0),
    .word1_o    (word1)
  );

  // ==========================================================
  // bus handshake, ack one cycle after the request is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= take;
    end
  end

  // read value selection
  logic [7:0] rd_val;

  always_comb begin
    rd_val = 8'h00;
    unique case (idx)
      sec_regs_pkg::IDX_CNT_TWO: rd_val = cnt_two;
      sec_regs_pkg::IDX_CNT_LO:  rd_val = capture ? cnt16[7:0] : hold_ff[7:0];
      sec_regs_pkg::IDX_CNT_HI:  rd_val = capture ? cnt16[15:8] : hold_ff[15:8];
      sec_regs_pkg::IDX_MASK:    rd_val = mask_ff;
      sec_regs_pkg::IDX_CFG:     rd_val = {1'b0, cfg_ff[6:5], sam_ff, cfg_ff[3:0]};
      sec_regs_pkg::IDX_PTR:     rd_val = {valid2_ff, ptr2_ff, valid1_ff, ptr1_ff};
      default:                   rd_val = 8'h00;
    endcase
  end

  // read data register and memory read select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff     <= 8'h00;
      mem_sel_ff <= 1'b0;
    end else if (take) begin
      dat_ff     <= rd_val;
      mem_sel_ff <= loc_acc & ~wb_we_i;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = {24'h000000, mem_sel_ff ? mem_rd : dat_ff};

  // ==========================================================
  // counter holding register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_ff     <= 16'h0000;
      hold_vld_ff <= 1'b0;
      hold_hi_ff  <= 1'b0;
    end else if (capture) begin
      hold_ff     <= cnt16;
      hold_vld_ff <= 1'b1;
      hold_hi_ff  <= (idx == sec_regs_pkg::IDX_CNT_HI);
    end else if (cnt_rd || (rd && idx == sec_regs_pkg::IDX_CNT_TWO)) begin
      hold_vld_ff <= 1'b0;
    end
  end

  // ==========================================================
  // configuration and mask registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= sec_regs_pkg::CFG_RST;
    end else if (wr && idx == sec_regs_pkg::IDX_CFG) begin
      cfg_ff <= wb_dat_i[7:0] & sec_regs_pkg::CFG_WR_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= sec_regs_pkg::MASK_RST;
    end else if (wr && idx == sec_regs_pkg::IDX_MASK) begin
      mask_ff <= wb_dat_i[7:0];
    end
  end

  // ==========================================================
  // location one pointer and valid flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr1_ff   <= sec_regs_pkg::PTR_RST;
      valid1_ff <= 1'b0;
    end else begin
      if (learn && !learn_loc) begin
        valid1_ff <= 1'b1;
        ptr1_ff   <= sec_regs_pkg::PTR_RST;
      end else if (loc_acc && !loc_sel && (rd || loc_wr)) begin
        ptr1_ff <= sec_regs_pkg::ptr_next(ptr1_ff);
      end
      if (wr && idx == sec_regs_pkg::IDX_PTR) begin
        valid1_ff <= wb_dat_i[sec_regs_pkg::VALID1];
      end
    end
  end

  // location two pointer and valid flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr2_ff   <= sec_regs_pkg::PTR_RST;
      valid2_ff <= 1'b0;
    end else begin
      if (learn && learn_loc) begin
        valid2_ff <= 1'b1;
        ptr2_ff   <= sec_regs_pkg::PTR_RST;
      end else if (loc_acc && loc_sel && (rd || loc_wr)) begin
        ptr2_ff <= sec_regs_pkg::ptr_next(ptr2_ff);
      end
      if (wr && idx == sec_regs_pkg::IDX_PTR) begin
        valid2_ff <= wb_dat_i[sec_regs_pkg::VALID2];
      end
    end
  end

  // ==========================================================
  // frame verdict, one cycle after the check strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      replace_ff   <= 1'b0;
      violation_ff <= 1'b0;
    end else begin
      replace_ff   <= frame_check_i & cfg_ff[sec_regs_pkg::CFG_SEC] & (viol | blocked);
      violation_ff <= frame_check_i & viol;
    end
  end

  // source check result, held until the next frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sam_ff <= 1'b0;
    end else if (frame_check_i) begin
      sam_ff <= src_mm;
    end
  end

  assign replace_o   = replace_ff;
  assign violation_o = violation_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_pulse;
    take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one cycle");

  property p_rsvd_zero;
    rd && idx == sec_regs_pkg::IDX_CFG |=> wb_dat_o[7] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

  property p_ptr_adv;
    wr && idx == sec_regs_pkg::IDX_LOC1 && !valid1_ff && !learn && ptr1_ff < 3'h5
      |=> ptr1_ff == $past(ptr1_ff) + 3'h1;
  endproperty
  a_ptr_adv: assert property (p_ptr_adv) else $error("pointer did not advance");

  property p_ptr_wrap;
    wr && idx == sec_regs_pkg::IDX_LOC1 && ptr1_ff == 3'h5 && !valid1_ff |=> ptr1_ff == 3'h0;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");

  property p_valid_block;
    wr && idx == sec_regs_pkg::IDX_LOC2 && valid2_ff && !learn |=> $stable(ptr2_ff);
  endproperty
  a_valid_block: assert property (p_valid_block) else $error("valid loc written");

  property p_bcast_repl;
    frame_check_i && cfg_ff[sec_regs_pkg::CFG_SEC] && bcast
      && !cfg_ff[sec_regs_pkg::CFG_BCAST] |=> replace_o;
  endproperty
  a_bcast_repl: assert property (p_bcast_repl) else $error("broadcast passed");

  property p_src_viol;
    frame_check_i && cfg_ff[sec_regs_pkg::CFG_SEC] && cfg_ff[sec_regs_pkg::CFG_SRC]
      && !src_hit |=> violation_o && replace_o && sam_ff;
  endproperty
  a_src_viol: assert property (p_src_viol) else $error("source mismatch missed");

  property p_hold_pair;
    rd && idx == sec_regs_pkg::IDX_CNT_LO && !capture |=> wb_dat_o[7:0] == $past(hold_ff[7:0]);
  endproperty
  a_hold_pair: assert property (p_hold_pair) else $error("copy not served");

  property p_mcast_repl;
    frame_check_i && cfg_ff[sec_regs_pkg::CFG_SEC] && mcast
      && !cfg_ff[sec_regs_pkg::CFG_MCAST] |=> replace_o;
  endproperty
  a_mcast_repl: assert property (p_mcast_repl) else $error("multicast passed");

  property p_dst_viol;
    frame_check_i && cfg_ff[sec_regs_pkg::CFG_SEC] && cfg_ff[sec_regs_pkg::CFG_DST]
      && !dst_hit |=> violation_o && replace_o;
  endproperty
  a_dst_viol: assert property (p_dst_viol) else $error("destination mismatch missed");

  c_learn:   cover property (learn);
  c_mc_pass: cover property (frame_check_i && mcast && cfg_ff[sec_regs_pkg::CFG_MCAST]);
  c_hold:    cover property (rd && idx == sec_regs_pkg::IDX_CNT_HI && !capture);

endmodule

// File: test/host_model.sv
// wishbone master standing in for the management processor
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk_i,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o
);
  // ==========================================================
  // idle bus at time zero
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'hF;
    wb_dat_o = 32'h0000_0000;
  end

  // one classic cycle, one address byte per access
  task automatic xfer(input logic we, input logic [5:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= {idx, 2'b00};
    wb_dat_o <= {24'h00_0000, wd};
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    rd = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_dat_o <= ~wb_dat_o; // released data no longer shows the last value
  endtask
endmodule

// File: test/port_address_security_regs_tb.sv
// self-checking bench for the per-port counter, security and address registers
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module port_address_security_regs_tb;
  localparam logic [5:0]  CNT2 = sec_regs_pkg::IDX_CNT_TWO;
  localparam logic [5:0]  CLO  = sec_regs_pkg::IDX_CNT_LO;
  localparam logic [5:0]  CHI  = sec_regs_pkg::IDX_CNT_HI;
  localparam logic [5:0]  MSK  = sec_regs_pkg::IDX_MASK;
  localparam logic [5:0]  CFG  = sec_regs_pkg::IDX_CFG;
  localparam logic [5:0]  PTR  = sec_regs_pkg::IDX_PTR;
  localparam logic [5:0]  LOC1 = sec_regs_pkg::IDX_LOC1;
  localparam logic [5:0]  LOC2 = sec_regs_pkg::IDX_LOC2;
  localparam logic [47:0] ADR1 = 48'h6655_4433_2210;
  localparam logic [47:0] ADR2 = 48'hA6A5_A4A3_A2A1;
  localparam logic [47:0] BC   = sec_regs_pkg::BCAST_ADDR;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ev    = 1'b0;
  logic        ev2   = 1'b0;
  logic        chk   = 1'b0;
  logic [47:0] src   = 48'h0;
  logic [47:0] dst   = 48'h0;
  logic        cyc, stb, we, ack, repl, viol;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dwr, drd;
  int          error_cnt = 0;
  int          samples_checked = 0;

  // ==========================================================
  // clock and instances
  always #2.5 clk_i = ~clk_i;

  host_model host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(drd), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dwr));

  port_security_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(drd),
    .wb_ack_o(ack), .event_i(ev), .event_two_i(ev2), .frame_check_i(chk),
    .src_addr_i(src), .dst_addr_i(dst), .replace_o(repl), .violation_o(viol));

  // ==========================================================
  // shared tasks
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [31:0] r;
    host.xfer(1'b1, i, d, r);
  endtask
  task automatic rdc(input logic [5:0] i, input logic [7:0] e);
    logic [31:0] r;
    host.xfer(1'b0, i, 8'h00, r);
    `CHK(r, {24'h00_0000, e})
  endtask
  task automatic rd_loc(input logic [5:0] i, input logic [47:0] a);
    for (int k = 0; k < 6; k++) begin
      rdc(i, a[8*k +: 8]);
    end
  endtask
  task automatic pulse(input logic two, input int n);
    repeat (n) begin
      @(posedge clk_i);
      if (two) ev2 <= 1'b1;
      else ev <= 1'b1;
      @(posedge clk_i);
      ev2 <= 1'b0;
      ev  <= 1'b0;
    end
  endtask
  task automatic frame(input logic [47:0] s, input logic [47:0] d, input logic er,
                       input logic evl);
    @(posedge clk_i);
    chk <= 1'b1;
    src <= s;
    dst <= d;
    @(posedge clk_i);
    chk <= 1'b0;
    #1;
    `CHK(repl, er)
    `CHK(viol, evl)
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rdc(CFG, 8'h00);
    rdc(PTR, 8'h00);
    rdc(MSK, 8'h00);
    rdc(CNT2, 8'h00);
    rdc(CHI, 8'h00);
    wr(6'h3F, 8'h5A);
    rdc(6'h3F, 8'h00);
    wr(CFG, 8'hFF);
    rdc(CFG, 8'h6F);
  endtask
  task automatic t_cnt2;
    wr(CFG, 8'h00);
    pulse(1'b1, 3);
    rdc(CNT2, 8'h03);
    rdc(CNT2, 8'h03);
    wr(MSK, 8'h01);
    rdc(CNT2, 8'h03);
    rdc(CNT2, 8'h00);
    wr(MSK, 8'h02);
    pulse(1'b1, 300);
    rdc(CNT2, 8'hFF);
    wr(MSK, 8'h00);
    pulse(1'b1, 1);
    rdc(CNT2, 8'h00);
  endtask
  task automatic t_cnt16;
    pulse(1'b0, 258);
    rdc(CLO, 8'h02);
    pulse(1'b0, 257);
    rdc(CHI, 8'h01);
    rdc(CHI, 8'h02);
    pulse(1'b0, 1);
    rdc(CLO, 8'h03);
    wr(MSK, 8'h04);
    rdc(CLO, 8'h04);
    rdc(CHI, 8'h02);
    rdc(CLO, 8'h00);
    wr(MSK, 8'h00);
  endtask
  task automatic t_addr;
    for (int k = 0; k < 6; k++) begin
      wr(LOC1, ADR1[8*k +: 8]);
      rdc(PTR, 8'((k + 1) % 6));
    end
    rd_loc(LOC1, ADR1);
    wr(PTR, 8'h08);
    wr(LOC1, 8'hAA);
    rdc(PTR, 8'h08);
    rd_loc(LOC1, ADR1);
  endtask
  task automatic t_frame;
    wr(CFG, 8'h22);
    frame(ADR1, 48'h2, 1'b0, 1'b0);
    rdc(CFG, 8'h22);
    frame(ADR2, 48'h2, 1'b1, 1'b1);
    rdc(CFG, 8'h32);
    wr(CFG, 8'h42);
    frame(ADR2, ADR1, 1'b0, 1'b0);
    frame(ADR1, 48'h2, 1'b1, 1'b1);
    wr(CFG, 8'h22);
    frame(ADR1, BC, 1'b1, 1'b0);
    frame(ADR1, 48'h1, 1'b1, 1'b0);
    wr(CFG, 8'h2E);
    frame(ADR1, BC, 1'b0, 1'b0);
    frame(ADR1, 48'h1, 1'b0, 1'b0);
    frame(ADR2, BC, 1'b1, 1'b1);
    wr(CFG, 8'h2C);
    frame(ADR2, BC, 1'b0, 1'b0);
  endtask
  task automatic t_learn;
    wr(CFG, 8'h01);
    frame(ADR2, 48'h2, 1'b0, 1'b0);
    rdc(PTR, 8'h88);
    wr(LOC2, 8'h55);
    rdc(PTR, 8'h88);
    rd_loc(LOC2, ADR2);
    wr(CFG, 8'h22);
    frame(ADR2, 48'h2, 1'b0, 1'b0);
    wr(PTR, 8'h80);
    frame(ADR1, 48'h2, 1'b1, 1'b1);
  endtask

  // reset in mid-run returns the pointer and config registers to zero
  task automatic t_rerst;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(PTR, 8'h00);
    rdc(CFG, 8'h00);
  endtask

  // ==========================================================
  // verdict, main sequence and watchdog
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_cnt2();
    t_cnt16();
    t_addr();
    t_frame();
    t_learn();
    t_rerst();
    close_out();
  end

  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
endmodule
